// ==== design/diag_status_pkg.sv ====
/*
  constants, field positions, reset values and types of the diagnostic
  status register bank of an eight-output half-bridge driver.
  assumes one core clock and a synchronous active-high reset.
*/
// Function
// - protocol fault bit seven, sticky until clear
// - bit six reads OR of all switch flags
// - summary falls alone once switch flags clear
// - undervoltage latches bit five, disables outputs
// - overvoltage latches bit four, disables outputs
// - bit three zero after reset, one after clear
// - thermal shutdown latches bit two, disables outputs
// - thermal prewarning sets bit one, disables nothing
// - bit zero reserved, always reads zero
// - first overcurrent byte: bridges four to one
// - second overcurrent byte: bridges eight to five
// - overcurrent latches and disables only that switch
// - three address bytes select the three registers
// - overcurrent flags reset to zero
// - command is address byte then data byte
// - address bit seven: zero reads, one clears
`default_nettype none

package diag_status_pkg;

  // one status register byte
  typedef logic [7:0]  reg_byte_t;
  // one 16-bit serial command, address byte on top
  typedef logic [15:0] frame_t;
  // one flag per switch, bit 2k+1 high side, bit 2k low side
  typedef logic [15:0] switch_vec_t;

  // address decode: bits 7 (access) and 1 (tail) are don't care
  localparam reg_byte_t ADDR_MASK       = 8'h7D;
  localparam reg_byte_t ADDR_GLOBAL     = 8'h19;
  localparam reg_byte_t ADDR_OC_LOW     = 8'h59;
  localparam reg_byte_t ADDR_OC_HIGH    = 8'h39;
  localparam int        ACCESS_OP_BIT   = 7;
  localparam int        ADDR_TAIL_BIT   = 1;

  // field positions of the global fault status register
  localparam int        BIT_PROTO_ERR   = 7;
  localparam int        BIT_LOAD_FAULT  = 6;
  localparam int        BIT_SUPPLY_LOW  = 5;
  localparam int        BIT_SUPPLY_HIGH = 4;
  localparam int        BIT_NO_POR      = 3;
  localparam int        BIT_THERM_SHUT  = 2;
  localparam int        BIT_THERM_WARN  = 1;
  localparam int        BIT_RESERVED    = 0;

  // values after reset
  localparam reg_byte_t   STATUS_RESET  = 8'h00;
  localparam switch_vec_t SWITCH_RESET  = 16'h0000;
  localparam logic        FLAG_RESET    = 1'b0;

  // synchroniser depth for monitor pins
  localparam int        SYNC_STAGES     = 2;

endpackage : diag_status_pkg

`default_nettype wire

// ==== design/diag_status_regs.sv ====
/*
  diagnostic status register bank: global fault status and two
  overcurrent status bytes, read or cleared by 16-bit serial commands.
  assumes a framing block on the same clock delivers each complete
  command as a one-cycle strobe and flags malformed frames by a pulse;
  analog monitor levels arrive asynchronously on pins; open-load flags
  come from a neighbouring register block on the same clock.
*/
`default_nettype none

module diag_status_regs
  import diag_status_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         frame_valid,
  input  wire diag_status_pkg::frame_t      frame_word,
  input  wire logic                         protocol_error,
  input  wire logic                         supply_low_pin,
  input  wire logic                         supply_high_pin,
  input  wire logic                         therm_shut_pin,
  input  wire logic                         therm_warn_pin,
  input  wire diag_status_pkg::switch_vec_t overcurrent_pin,
  input  wire diag_status_pkg::switch_vec_t open_load_flags,
  output diag_status_pkg::reg_byte_t        resp_data,
  output logic                              resp_valid,
  output logic                              all_outputs_off,
  output diag_status_pkg::switch_vec_t      switch_off
);

  import diag_status_pkg::*;

  // decode helper: address byte selects a register
  function automatic logic addr_hit(input reg_byte_t addr,
                                    input reg_byte_t target);
    addr_hit = ((addr & ADDR_MASK) == target);
  endfunction : addr_hit

  // monitor levels after two flip-flops
  logic [19:0]  mon_sync;             // all synchronised monitors
  logic         supply_low_s;         // undervoltage present
  logic         supply_high_s;        // overvoltage present
  logic         therm_shut_s;         // shutdown threshold reached
  logic         therm_warn_s;         // prewarning threshold reached
  switch_vec_t  overcurrent_s;        // per-switch overcurrent present

  // latched flags of the global register
  logic         proto_err_flag;       // malformed serial transfer seen
  logic         supply_low_flag;      // undervoltage latched
  logic         supply_high_flag;     // overvoltage latched
  logic         no_power_on_reset_flag; // no reset since last clear
  logic         thermal_shutdown_flag;  // thermal shutdown latched
  logic         thermal_prewarn_flag;   // prewarning latched
  logic         load_fault_summary;   // OR of every switch flag

  // decoded command
  reg_byte_t    addr_byte;            // upper byte of the command
  logic         access_op_bit;        // one clears, zero reads
  logic         hit_global;           // global register addressed
  logic         hit_oc_low;           // bridges 1 to 4 addressed
  logic         hit_oc_high;          // bridges 5 to 8 addressed
  logic         clr_global;           // clear of global register
  logic         clr_oc_low;           // clear of bridges 1 to 4
  logic         clr_oc_high;          // clear of bridges 5 to 8
  reg_byte_t    global_byte;          // current global register

  // next values
  logic         next_proto_err;
  logic         next_supply_low;
  logic         next_supply_high;
  logic         next_no_por;
  logic         next_therm_shut;
  logic         next_therm_warn;
  switch_vec_t  next_switch_off;
  logic         next_all_off;
  reg_byte_t    next_resp_data;
  logic         next_resp_valid;

  // monitor pins come from the analog domain
  monitor_sync #(
    .WIDTH (20)
  ) u_monitor_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({therm_warn_pin, therm_shut_pin, supply_high_pin,
                supply_low_pin, overcurrent_pin}),
    .sync_out (mon_sync)
  );

  // split the synchronised group
  always_comb begin
    overcurrent_s = mon_sync[15:0];
    supply_low_s  = mon_sync[16];
    supply_high_s = mon_sync[17];
    therm_shut_s  = mon_sync[18];
    therm_warn_s  = mon_sync[19];
  end

  // command decode and global register image
  always_comb begin
    addr_byte     = frame_word[15:8];
    access_op_bit = addr_byte[ACCESS_OP_BIT];
    hit_global    = frame_valid && addr_hit(addr_byte, ADDR_GLOBAL);
    hit_oc_low    = frame_valid && addr_hit(addr_byte, ADDR_OC_LOW);
    hit_oc_high   = frame_valid && addr_hit(addr_byte, ADDR_OC_HIGH);
    clr_global    = hit_global && access_op_bit;
    clr_oc_low    = hit_oc_low && access_op_bit;
    clr_oc_high   = hit_oc_high && access_op_bit;
    // summary needs no clear of its own; it follows the flags
    load_fault_summary = (|switch_off) || (|open_load_flags);
    global_byte = STATUS_RESET;
    global_byte[BIT_PROTO_ERR]   = proto_err_flag;
    global_byte[BIT_LOAD_FAULT]  = load_fault_summary;
    global_byte[BIT_SUPPLY_LOW]  = supply_low_flag;
    global_byte[BIT_SUPPLY_HIGH] = supply_high_flag;
    global_byte[BIT_NO_POR]      = no_power_on_reset_flag;
    global_byte[BIT_THERM_SHUT]  = thermal_shutdown_flag;
    global_byte[BIT_THERM_WARN]  = thermal_prewarn_flag;
    global_byte[BIT_RESERVED]    = 1'b0;
  end

  // next flag values: a detection in the clear cycle wins
  always_comb begin
    next_proto_err   = protocol_error ||
                       (proto_err_flag && !clr_global);
    next_supply_low  = supply_low_s ||
                       (supply_low_flag && !clr_global);
    next_supply_high = supply_high_s ||
                       (supply_high_flag && !clr_global);
    next_therm_shut  = therm_shut_s ||
                       (thermal_shutdown_flag && !clr_global);
    next_therm_warn  = therm_warn_s ||
                       (thermal_prewarn_flag && !clr_global);
    // reset shows zero; a clear of the register arms it to one
    next_no_por = no_power_on_reset_flag || clr_global;
    // per-switch latch, each flag disables only its own switch
    next_switch_off[7:0]  = overcurrent_s[7:0] |
                            (switch_off[7:0] & ~{8{clr_oc_low}});
    next_switch_off[15:8] = overcurrent_s[15:8] |
                            (switch_off[15:8] & ~{8{clr_oc_high}});
    // prewarning stays out of the global disable
    next_all_off = next_supply_low || next_supply_high ||
                   next_therm_shut;
  end

  // in-frame answer: value before any clear of this frame
  always_comb begin
    next_resp_valid = frame_valid;
    next_resp_data  = STATUS_RESET;
    if (hit_global) begin
      next_resp_data = global_byte;
    end else if (hit_oc_low) begin
      next_resp_data = switch_off[7:0];
    end else if (hit_oc_high) begin
      next_resp_data = switch_off[15:8];
    end
  end

  // register flags, disables and answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      proto_err_flag         <= FLAG_RESET;
      supply_low_flag        <= FLAG_RESET;
      supply_high_flag       <= FLAG_RESET;
      no_power_on_reset_flag <= FLAG_RESET;
      thermal_shutdown_flag  <= FLAG_RESET;
      thermal_prewarn_flag   <= FLAG_RESET;
      switch_off             <= SWITCH_RESET;
      all_outputs_off        <= FLAG_RESET;
      resp_data              <= STATUS_RESET;
      resp_valid             <= FLAG_RESET;
    end else begin
      proto_err_flag         <= next_proto_err;
      supply_low_flag        <= next_supply_low;
      supply_high_flag       <= next_supply_high;
      no_power_on_reset_flag <= next_no_por;
      thermal_shutdown_flag  <= next_therm_shut;
      thermal_prewarn_flag   <= next_therm_warn;
      switch_off             <= next_switch_off;
      all_outputs_off        <= next_all_off;
      resp_data              <= next_resp_data;
      resp_valid             <= next_resp_valid;
    end
  end

  // checks on the register bank
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // protocol fault caught next cycle and held one more cycle unless cleared
  a_proto_err_latch: assert property (
    protocol_error |=> proto_err_flag ##1 (proto_err_flag || $past(clr_global))
  ) else $error("protocol fault flag not latched");

  // summary bit in the answer equals OR of all switch flags
  a_load_fault_or: assert property (
    hit_global |=> resp_data[BIT_LOAD_FAULT] ==
                   ($past(|switch_off) || $past(|open_load_flags))
  ) else $error("load fault summary wrong");

  // summary reads zero when no switch flag is left
  a_load_fault_drop: assert property (
    (hit_global && switch_off == '0 && open_load_flags == '0)
      |=> !resp_data[BIT_LOAD_FAULT]
  ) else $error("load fault summary did not fall");

  // undervoltage disables all outputs one cycle after sync
  a_uv_disable: assert property (
    supply_low_s |=> supply_low_flag && all_outputs_off
  ) else $error("undervoltage did not disable outputs");

  // overvoltage disables all outputs one cycle after sync
  a_ov_disable: assert property (
    supply_high_s |=> supply_high_flag && all_outputs_off
  ) else $error("overvoltage did not disable outputs");

  // no-reset flag zero after reset, one after a global clear
  a_no_reset_value: assert property (
    ($past(rst) |-> !no_power_on_reset_flag) and
    (clr_global |=> no_power_on_reset_flag)
  ) else $error("no-reset flag wrong");

  // shutdown disables, prewarning alone does not
  a_thermal_disable: assert property (
    all_outputs_off == (supply_low_flag || supply_high_flag ||
                        thermal_shutdown_flag)
  ) else $error("global disable mismatch");

  // prewarning flag set next cycle
  a_prewarn_set: assert property (
    therm_warn_s |=> thermal_prewarn_flag
  ) else $error("prewarning flag not set");

  // reserved bit of the global register reads zero
  a_reserved_zero: assert property (
    hit_global |=> !resp_data[BIT_RESERVED]
  ) else $error("reserved bit not zero");

  // overcurrent bytes answer with the right halves
  a_oc_low_map: assert property (
    hit_oc_low |=> resp_valid && resp_data == $past(switch_off[7:0])
  ) else $error("low overcurrent byte wrong");
  a_oc_high_map: assert property (
    hit_oc_high |=> resp_data == $past(switch_off[15:8])
  ) else $error("high overcurrent byte wrong");

  // overcurrent disables exactly its own switch
  a_oc_own_switch: assert property (
    1'b1 |=> (switch_off & ~$past(switch_off) & ~$past(overcurrent_s))
             == '0 &&
             (switch_off & $past(overcurrent_s)) == $past(overcurrent_s)
  ) else $error("switch disable not per switch");

  // low-byte overcurrent flags stay until the low byte is cleared
  a_oc_sticky: assert property (
    !clr_oc_low |=> (switch_off[7:0] & $past(switch_off[7:0])) ==
                    $past(switch_off[7:0])
  ) else $error("overcurrent flag fell without clear");

  // overcurrent flags zero right after reset
  a_oc_reset_zero: assert property (
    $past(rst) |-> switch_off == SWITCH_RESET
  ) else $error("overcurrent flags not reset");

  // clear without fault empties its byte, low or high; fault still present refills
  a_oc_clear: assert property (
    clr_oc_low |=> switch_off[7:0] == $past(overcurrent_s[7:0])
  ) else $error("overcurrent clear wrong");
  a_oc_high_clear: assert property (
    clr_oc_high |=> switch_off[15:8] == $past(overcurrent_s[15:8])
  ) else $error("high overcurrent clear wrong");

  // a global clear with no cause present drops every latched flag except the no-reset flag, which it sets
  a_global_clear: assert property (
    (clr_global && !protocol_error && !supply_low_s && !supply_high_s &&
     !therm_shut_s && !therm_warn_s) |=>
      !(proto_err_flag || supply_low_flag || supply_high_flag ||
        thermal_shutdown_flag || thermal_prewarn_flag)
  ) else $error("global clear left a flag");

  // a cause present in the clear cycle keeps its flag set
  a_set_beats_clear: assert property (
    clr_global |=> (proto_err_flag || !$past(protocol_error)) &&
                   (supply_low_flag || !$past(supply_low_s)) &&
                   (thermal_shutdown_flag || !$past(therm_shut_s))
  ) else $error("clear beat a present fault");

  // latched supply and shutdown flags never fall on their own
  a_no_self_clear: assert property (
    !clr_global |=> (supply_low_flag || !$past(supply_low_flag)) &&
                    (supply_high_flag || !$past(supply_high_flag)) &&
                    (thermal_shutdown_flag ||
                     !$past(thermal_shutdown_flag))
  ) else $error("latched flag fell by itself");

  // every command answers exactly one cycle later
  a_resp_strobe: assert property (
    1'b1 |=> resp_valid == $past(frame_valid)
  ) else $error("answer strobe misplaced");

  // an address that selects nothing answers zero
  a_unmapped_zero: assert property (
    (frame_valid && !hit_global && !hit_oc_low && !hit_oc_high) |=>
      resp_data == STATUS_RESET
  ) else $error("unmapped address answered");

  // main scenarios
  c_clear_global: cover property (clr_global ##1 resp_valid);
  c_oc_latched:   cover property (overcurrent_s != '0 ##1 hit_oc_low);
  c_uv_cleared:   cover property (supply_low_flag ##1 clr_global);
  c_summary_fall: cover property ($fell(load_fault_summary));
  c_set_wins:     cover property (clr_global && protocol_error);

endmodule : diag_status_regs

`default_nettype wire

// ==== design/monitor_sync.sv ====
/*
  two-stage synchroniser for a group of level inputs from analog monitors.
  assumes the inputs are slow levels; no pulse shorter than one clock
  is guaranteed to pass.
*/
`default_nettype none

module monitor_sync #(
  parameter int WIDTH = 20
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // first stage, read only by the second stage
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  // refuse a group width of zero
  if (WIDTH < 1) begin : g_width_check
    $error("monitor_sync needs a width of at least one");
  end

  // next values: shift one stage per clock
  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  // register both stages, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : monitor_sync

`default_nettype wire

// ==== verification/diag_status_regs_tb.sv ====
/*
  self-checking bench of the diagnostic status bank: reset values,
  read and clear commands, monitor faults, overcurrent and summary.
  assumes the serial master model issues frames; inputs change on the
  falling edge of a 100 MHz clock.
*/
`default_nettype none

module diag_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import diag_status_pkg::*;

  logic        clk_sys;          // core clock
  logic        rst;              // synchronous reset
  logic        frame_valid;      // command strobe from master
  frame_t      frame_word;       // command word
  logic        protocol_error;   // malformed frame pulse
  logic        supply_low_pin;   // undervoltage level
  logic        supply_high_pin;  // overvoltage level
  logic        therm_shut_pin;   // shutdown temperature level
  logic        therm_warn_pin;   // prewarning temperature level
  switch_vec_t overcurrent_pin;  // per-switch overcurrent levels
  switch_vec_t open_load_flags;  // per-switch open-load flags
  reg_byte_t   resp_data;        // answer byte
  logic        resp_valid;       // answer strobe
  logic        all_outputs_off;  // global disable
  switch_vec_t switch_off;       // per-switch disable
  int          fail_count;       // mismatches seen
  int          checks_done;      // comparisons made
  int          cycles;           // timeout counter

  // global status bit of each monitor, in monitor order
  localparam reg_byte_t MON_BIT [4] = '{8'h20, 8'h10, 8'h04, 8'h02};

  diag_status_regs u_diag_status_regs (
    .clk_sys(clk_sys), .rst(rst), .frame_valid(frame_valid),
    .frame_word(frame_word), .protocol_error(protocol_error),
    .supply_low_pin(supply_low_pin), .supply_high_pin(supply_high_pin),
    .therm_shut_pin(therm_shut_pin), .therm_warn_pin(therm_warn_pin),
    .overcurrent_pin(overcurrent_pin), .open_load_flags(open_load_flags),
    .resp_data(resp_data), .resp_valid(resp_valid),
    .all_outputs_off(all_outputs_off), .switch_off(switch_off)
  );

  serial_master_model u_serial_master_model (
    .clk_sys(clk_sys), .frame_valid(frame_valid),
    .frame_word(frame_word), .resp_data(resp_data),
    .resp_valid(resp_valid)
  );

  // 100 MHz clock
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      complete_run();
    end
  end

  // verdict and end of run
  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // one comparison, counted
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : check

  // one command and a check of its answer byte
  task automatic rd(input reg_byte_t addr, input reg_byte_t exp,
                    input string what);
    reg_byte_t data;
    logic      got;
    u_serial_master_model.xfer(addr, data, got);
    check({15'h0000, got}, 16'h0001, "answer strobe");
    check({8'h00, data}, {8'h00, exp}, what);
  endtask : rd

  // drive one analog monitor level
  task automatic set_mon(input int k, input logic v);
    case (k)
      0: supply_low_pin = v;
      1: supply_high_pin = v;
      2: therm_shut_pin = v;
      default: therm_warn_pin = v;
    endcase
  endtask : set_mon

  // reset contents, unmapped address, first clear of the global byte
  task automatic test_reset_state();
    check({15'h0000, all_outputs_off}, 16'h0000, "off after reset");
    check(switch_off, SWITCH_RESET, "switches after reset");
    rd(8'h19, 8'h00, "global after reset");
    rd(8'h59, 8'h00, "oc low after reset");
    rd(8'h39, 8'h00, "oc high after reset");
    rd(8'h7F, 8'h00, "unmapped address");
    rd(8'h99, 8'h00, "clear answer");
    rd(8'h1B, 8'h08, "global after clear");
  endtask : test_reset_state

  // protocol fault is sticky until cleared
  task automatic test_protocol();
    @(negedge clk_sys);
    protocol_error = 1'b1;
    @(negedge clk_sys);
    protocol_error = 1'b0;
    rd(8'h19, 8'h88, "protocol flag");
    rd(8'h19, 8'h88, "protocol flag kept");
    rd(8'h99, 8'h88, "protocol clear answer");
    // a new fault in the very cycle of a clear must win
    fork
      rd(8'h99, 8'h08, "clear beside new fault");
      begin
        @(negedge clk_sys);
        protocol_error = 1'b1;
        @(negedge clk_sys);
        protocol_error = 1'b0;
      end
    join
    rd(8'h19, 8'h88, "set beats clear");
    rd(8'h99, 8'h88, "protocol clear again");
    rd(8'h19, 8'h08, "protocol flag cleared");
  endtask : test_protocol

  // supply and thermal monitors: latch, disable, clear while present
  task automatic test_monitors();
    for (int k = 0; k < 4; k++) begin
      set_mon(k, 1'b1);
      repeat (4) @(negedge clk_sys);
      check({15'h0000, all_outputs_off}, {15'h0000, k != 3},
            "global disable");
      rd(8'h99, 8'h08 | MON_BIT[k], "monitor flag");
      rd(8'h19, 8'h08 | MON_BIT[k], "flag set again");
      set_mon(k, 1'b0);
      repeat (3) @(negedge clk_sys);
      rd(8'h19, 8'h08 | MON_BIT[k], "flag latched");
      rd(8'h99, 8'h08 | MON_BIT[k], "monitor clear");
      rd(8'h19, 8'h08, "monitor cleared");
      check({15'h0000, all_outputs_off}, 16'h0000, "outputs back");
    end
  endtask : test_monitors

  // each switch alone: own disable, byte placement, summary
  task automatic test_overcurrent();
    switch_vec_t one;
    for (int b = 0; b < 16; b++) begin
      one = 16'h0001 << b;
      overcurrent_pin = one;
      repeat (4) @(negedge clk_sys);
      check(switch_off, one, "only that switch off");
      check({15'h0000, all_outputs_off}, 16'h0000, "others on");
      overcurrent_pin = 16'h0000;
      rd(8'h59, one[7:0], "oc low byte");
      rd(8'h39, one[15:8], "oc high byte");
      rd(8'h19, 8'h48, "summary set");
      rd(8'hD9, one[7:0], "oc low clear");
      rd(8'hBB, one[15:8], "oc high clear");
      rd(8'h19, 8'h08, "summary fell");
      check(switch_off, 16'h0000, "switch back on");
    end
  endtask : test_overcurrent

  // open-load flags feed the summary, which no clear can remove
  task automatic test_open_load();
    open_load_flags = 16'h8000;
    rd(8'h19, 8'h48, "summary from open load");
    rd(8'h99, 8'h48, "summary not clearable");
    rd(8'h19, 8'h48, "summary kept after clear");
    open_load_flags = 16'h0000;
    rd(8'h19, 8'h08, "summary follows flags");
  endtask : test_open_load

  // second reset clears a set flag and the no-reset flag
  task automatic test_second_reset();
    @(negedge clk_sys);
    protocol_error = 1'b1;
    @(negedge clk_sys);
    protocol_error = 1'b0;
    rd(8'h19, 8'h88, "flag before reset");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check(switch_off, SWITCH_RESET, "switches after reset");
    rd(8'h19, 8'h00, "global after reset");
  endtask : test_second_reset

  // main sequence
  initial begin
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    rst = 1'b1;
    protocol_error = 1'b0;
    supply_low_pin = 1'b0;
    supply_high_pin = 1'b0;
    therm_shut_pin = 1'b0;
    therm_warn_pin = 1'b0;
    overcurrent_pin = 16'h0000;
    open_load_flags = 16'h0000;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    test_reset_state();
    test_protocol();
    test_monitors();
    test_overcurrent();
    test_open_load();
    test_second_reset();
    complete_run();
  end

endmodule : diag_status_regs_tb

`default_nettype wire

// ==== verification/serial_master_model.sv ====
/*
  behavioural serial master that issues 16-bit status commands to the
  diagnostic status bank and samples the one-byte answer.
  assumes the bank answers one cycle after it takes a frame and that
  the bench drives the clock; requests change on the falling edge.
*/
`default_nettype none

module serial_master_model (
  input  wire logic                       clk_sys,
  output var  logic                       frame_valid,
  output var  diag_status_pkg::frame_t    frame_word,
  input  wire diag_status_pkg::reg_byte_t resp_data,
  input  wire logic                       resp_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import diag_status_pkg::*;

  // idle bus: no request pending
  initial begin
    frame_valid = 1'b0;
    frame_word  = 16'h0000;
  end

  // one command: address byte on top, filler data byte below
  task automatic xfer(input reg_byte_t addr, output reg_byte_t data,
                      output logic got);
    @(negedge clk_sys);
    frame_word  <= {addr, 8'hA5};
    frame_valid <= 1'b1;
    @(negedge clk_sys);
    frame_valid <= 1'b0;
    // released word does not keep its last value
    frame_word  <= ~{addr, 8'hA5};
    got  = resp_valid;
    data = resp_data;
  endtask : xfer

endmodule : serial_master_model

`default_nettype wire
